// *** hdl/sbrb_bank.v ***
/*
 * Serial-port register bank: control registers written by 16-bit frames,
 * clearable and live status registers, and the hardware updates applied
 * on operating-mode changes. Assumes SCLK idles low, serial clock at most
 * sys_clk/8, frames LSB first, and a same-clock mode state machine.
 */
// Contract
// - Addresses 0x00-0x1E are control; bit 7 low reads, high also writes.
// - A written value shows only in a later frame to that register.
// - Addresses 0x40-0x7E are status; bit 7 high clears clearable bits.
// - Wake level, identifier and selective-wake registers ignore clears.
// - Every mode change writes the entered mode into the mode field.
// - Stop or sleep keep diagnosis bits; a triggered fail output stays.
// - Entering stop leaves transceiver control bits untouched.
// - Entering sleep rewrites transceiver bits unless off or wake-capable.
// - Switch and regulator config is accepted only in normal mode.
// - Switch diagnosis stays active; a failure turns that switch off.
// - Entering restart clears switch and second regulator config.
// - Hardware updates of control bits override software writes.
// - Frame: bits 6-0 address, bit 7 action, bits 15-8 data.
// - Frames received in restart mode are not interpreted.
`timescale 1ns/10ps
`include "sbrb_map.vh"

module sbrb_bank #(
   parameter N_HS   = 2,
   parameter N_STAT = 8,
   parameter N_LIVE = 7,
   parameter [7:0] FAM_PROD_ID = 8'h5A  // Arbitrary identifier value.
) (
   // Clock and reset
   sys_clk,
   srst,
   // Serial port pins
   spi_cs_n,
   spi_sclk,
   spi_sdi,
   spi_sdo,
   spi_sdo_oe,
   // Mode state machine and diagnosis
   mode_now,
   hs_fail,
   fail_trigger,
   stat_set,
   stat_live,
   fail_out,
   // Control register contents
   mode_select_control,
   hardware_control,
   watchdog_control,
   bus_control_one,
   bus_control_two,
   wake_control_one,
   wake_control_two,
   wake_pull_control,
   wake_filter_control,
   timer_one_control,
   timer_two_control,
   switch_shutdown_control,
   high_side_control_one
);
   input  wire                sys_clk;
   input  wire                srst;
   input  wire                spi_cs_n;
   input  wire                spi_sclk;
   input  wire                spi_sdi;
   output reg                 spi_sdo;
   output reg                 spi_sdo_oe;
   input  wire [2:0]          mode_now;
   input  wire [N_HS-1:0]     hs_fail;
   input  wire                fail_trigger;
   input  wire [N_STAT*8-1:0] stat_set;
   input  wire [N_LIVE*8-1:0] stat_live;
   output reg                 fail_out;
   output wire [7:0]          mode_select_control;
   output wire [7:0]          hardware_control;
   output wire [7:0]          watchdog_control;
   output wire [7:0]          bus_control_one;
   output wire [7:0]          bus_control_two;
   output wire [7:0]          wake_control_one;
   output wire [7:0]          wake_control_two;
   output wire [7:0]          wake_pull_control;
   output wire [7:0]          wake_filter_control;
   output wire [7:0]          timer_one_control;
   output wire [7:0]          timer_two_control;
   output wire [7:0]          switch_shutdown_control;
   output wire [7:0]          high_side_control_one;

   localparam N_CTRL = 13;
   localparam [3:0] IX_MODE = 4'h0;
   localparam [3:0] IX_HW   = 4'h1;
   localparam [3:0] IX_BUS1 = 4'h3;
   localparam [3:0] IX_HS1  = 4'hC;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and edge detection.

   wire [2:0] pins_s;
   reg        sclk_d_q;
   reg        cs_d_q;
   wire       cs_n_s;
   wire       sclk_s;
   wire       sdi_s;

   sbrb_sync #(
      .WIDTH    (3)
   ) u_sync (
      .sys_clk  (sys_clk),
      .async_in ({spi_cs_n, spi_sclk, spi_sdi}),
      .sync_out (pins_s)
   );

   assign cs_n_s = pins_s[2];
   assign sclk_s = pins_s[1];
   assign sdi_s  = pins_s[0];

   wire sclk_rise = sclk_s & ~sclk_d_q & ~cs_n_s;
   wire sclk_fall = ~sclk_s & sclk_d_q & ~cs_n_s;
   wire cs_rise   = cs_n_s & ~cs_d_q;
   wire cs_fall   = ~cs_n_s & cs_d_q;

   ////////////////////////////////////////////////////////////////////////
   // Register storage and address decode.

   reg  [7:0] ctrl_q [0:N_CTRL-1];
   reg  [7:0] stat_q [0:N_STAT-1];
   reg  [2:0] mode_prev_q;

   function [4:0] ctrl_decode;   // {hit, index}
      input [6:0] addr;
      begin
         case (addr)
            `SBRB_ADDR_MODE_SEL:  ctrl_decode = 5'h10;
            `SBRB_ADDR_HW_CTL:    ctrl_decode = 5'h11;
            `SBRB_ADDR_WDOG_CTL:  ctrl_decode = 5'h12;
            `SBRB_ADDR_BUS_ONE:   ctrl_decode = 5'h13;
            `SBRB_ADDR_BUS_TWO:   ctrl_decode = 5'h14;
            `SBRB_ADDR_WAKE_ONE:  ctrl_decode = 5'h15;
            `SBRB_ADDR_WAKE_TWO:  ctrl_decode = 5'h16;
            `SBRB_ADDR_WAKE_PULL: ctrl_decode = 5'h17;
            `SBRB_ADDR_WAKE_FILT: ctrl_decode = 5'h18;
            `SBRB_ADDR_TMR_ONE:   ctrl_decode = 5'h19;
            `SBRB_ADDR_TMR_TWO:   ctrl_decode = 5'h1A;
            `SBRB_ADDR_SW_SHDN:   ctrl_decode = 5'h1B;
            `SBRB_ADDR_HS_ONE:    ctrl_decode = 5'h1C;
            default:              ctrl_decode = 5'h00;
         endcase
      end
   endfunction

   reg  [15:0] rx_q;
   reg  [4:0]  bit_cnt_q;
   reg  [7:0]  tx_q;
   wire [6:0]  rx_addr_now = rx_q[15:9];

   // Read value of any address as seen by the frame in progress.
   reg  [7:0] rd_val;
   reg  [4:0] rd_dec;
   always @* begin
      rd_dec = ctrl_decode(rx_addr_now);
      rd_val = 8'h00;
      if (rd_dec[4]) begin
         rd_val = ctrl_q[rd_dec[3:0]];
      end else if (rx_addr_now[6:3] == `SBRB_STAT_CLR_BASE) begin
         rd_val = stat_q[rx_addr_now[2:0]];
      end else if (rx_addr_now == `SBRB_ADDR_FAM_PROD) begin
         rd_val = FAM_PROD_ID;
      end else if (rx_addr_now[6:3] == `SBRB_STAT_LIVE_BASE &&
                   rx_addr_now[2:0] < N_LIVE) begin
         // Slots with no live byte behind them read as zero, never unknown.
         rd_val = stat_live[rx_addr_now[2:0]*8 +: 8];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame receiver and response shifter.

   always @(posedge sys_clk) begin
      if (srst) begin
         sclk_d_q   <= 1'b0;
         cs_d_q     <= 1'b1;
         rx_q       <= 16'h0000;
         bit_cnt_q  <= 5'h00;
         tx_q       <= 8'h00;
         spi_sdo    <= 1'b0;
         spi_sdo_oe <= 1'b0;
      end else begin
         sclk_d_q   <= sclk_s;
         cs_d_q     <= cs_n_s;
         spi_sdo_oe <= ~cs_n_s;
         if (cs_fall) begin
            bit_cnt_q <= 5'h00;
            spi_sdo   <= 1'b0;
         end
         if (sclk_rise) begin
            rx_q <= {sdi_s, rx_q[15:1]};
            if (bit_cnt_q != 5'h1F) begin
               bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            // Snapshot taken before any clear of this frame acts.
            if (bit_cnt_q == `SBRB_ADDR_BITS) begin
               tx_q <= rd_val;
            end
         end
         if (sclk_fall) begin
            if (bit_cnt_q[4:3] == 2'b01) begin
               spi_sdo <= tx_q[0];
               tx_q    <= {1'b0, tx_q[7:1]};
            end else begin
               spi_sdo <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame end: decode the completed frame.

   wire       in_restart = (mode_now == `SBRB_MODE_RESTART);
   wire       in_normal  = (mode_now == `SBRB_MODE_NORMAL);
   wire [6:0] f_addr     = rx_q[6:0];
   wire       f_act      = rx_q[`SBRB_BIT_ACT];
   wire [7:0] f_data     = rx_q[15:8];
   // Frames of the wrong length and frames in restart are dropped whole.
   wire       f_ok       = cs_rise & (bit_cnt_q == `SBRB_FRAME_BITS)
                           & ~in_restart;
   wire [4:0] f_dec      = ctrl_decode(f_addr);
   wire       f_wr       = f_ok & f_act & f_dec[4];
   wire       f_clr      = f_ok & f_act
                           & (f_addr[6:3] == `SBRB_STAT_CLR_BASE);

   ////////////////////////////////////////////////////////////////////////
   // Clearable status bank: set wins over a clear in the same cycle.

   genvar si;
   generate
      for (si = 0; si < N_STAT; si = si + 1) begin : g_stat
         wire hit = f_clr & (f_addr[2:0] == si);
         always @(posedge sys_clk) begin
            if (srst) begin
               stat_q[si] <= `SBRB_STAT_RST;
            end else begin
               // Mode changes never touch these bits.
               stat_q[si] <= (stat_q[si] & {8{~hit}})
                             | stat_set[si*8 +: 8];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Control bank: software write, then hardware overrides.

   wire       mode_chg = (mode_now != mode_prev_q);
   wire [1:0] can_fld  = ctrl_q[IX_BUS1][`SBRB_CAN_HI:`SBRB_CAN_LO];
   reg  [7:0] wr_val;

   // Writes outside normal mode leave the switch and regulator fields at their stored value.
   always @* begin
      wr_val = f_data;
      if (!in_normal) begin
         if (f_dec[3:0] == IX_HS1) begin
            wr_val = ctrl_q[IX_HS1];
         end else if (f_dec[3:0] == IX_HW) begin
            wr_val[`SBRB_SECOND_REGULATOR_OUTPUT_HI:`SBRB_SECOND_REGULATOR_OUTPUT_LO] =
               ctrl_q[IX_HW][`SBRB_SECOND_REGULATOR_OUTPUT_HI:`SBRB_SECOND_REGULATOR_OUTPUT_LO];
         end
      end
   end

   integer ci;
   integer hi;
   always @(posedge sys_clk) begin
      if (srst) begin
         for (ci = 0; ci < N_CTRL; ci = ci + 1) begin
            ctrl_q[ci] <= `SBRB_CTRL_RST;
         end
         mode_prev_q <= `SBRB_MODE_NORMAL;
      end else begin
         mode_prev_q <= mode_now;
         // The new value is stored at frame end, so only later frames see it.
         if (f_wr) begin
            ctrl_q[f_dec[3:0]] <= wr_val;
         end
         // Later assignments below take precedence over the software write.
         if (mode_chg) begin
            ctrl_q[IX_MODE] <= {mode_now,
                                wr_val[`SBRB_MODE_LO-1:0] & {5{f_wr &
                                (f_dec[3:0] == IX_MODE)}}
                                | ctrl_q[IX_MODE][`SBRB_MODE_LO-1:0] & {5{~(
                                f_wr & (f_dec[3:0] == IX_MODE))}}};
            if (mode_now == `SBRB_MODE_SLEEP &&
                can_fld != `SBRB_CAN_OFF && can_fld != `SBRB_CAN_WAKE) begin
               ctrl_q[IX_BUS1][`SBRB_CAN_HI:`SBRB_CAN_LO] <=
                  `SBRB_CAN_WAKE;
            end
            // Stop mode deliberately leaves the transceiver field alone.
            if (mode_now == `SBRB_MODE_RESTART) begin
               ctrl_q[IX_HS1] <= 8'h00;
               ctrl_q[IX_HW][`SBRB_SECOND_REGULATOR_OUTPUT_HI:`SBRB_SECOND_REGULATOR_OUTPUT_LO] <= 2'h0;
            end
         end
         for (hi = 0; hi < N_HS; hi = hi + 1) begin
            if (hs_fail[hi]) begin
               ctrl_q[IX_HS1][hi*`SBRB_HS_FIELD_W +: `SBRB_HS_FIELD_W]
                  <= 4'h0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fail output: once triggered it holds through every mode change.

   always @(posedge sys_clk) begin
      if (srst) begin
         fail_out <= 1'b0;
      end else if (fail_trigger) begin
         fail_out <= 1'b1;
      end
   end

   // Outputs are the storage flip-flops themselves; an active failure flag
   // holds its switch field at zero, overriding any write.
   assign mode_select_control     = ctrl_q[0];
   assign hardware_control        = ctrl_q[1];
   assign watchdog_control        = ctrl_q[2];
   assign bus_control_one         = ctrl_q[3];
   assign bus_control_two         = ctrl_q[4];
   assign wake_control_one        = ctrl_q[5];
   assign wake_control_two        = ctrl_q[6];
   assign wake_pull_control       = ctrl_q[7];
   assign wake_filter_control     = ctrl_q[8];
   assign timer_one_control       = ctrl_q[9];
   assign timer_two_control       = ctrl_q[10];
   assign switch_shutdown_control = ctrl_q[11];
   assign high_side_control_one   = ctrl_q[12];

endmodule // sbrb_bank

// *** hdl/sbrb_map.vh ***
/*
 * Address map, field positions, mode codes and reset values of the serial
 * register bank. Included by the bank; holds definitions only.
 */
`ifndef SBRB_MAP_VH
`define SBRB_MAP_VH

// Control register addresses (7-bit).
`define SBRB_ADDR_MODE_SEL    7'h01
`define SBRB_ADDR_HW_CTL      7'h02
`define SBRB_ADDR_WDOG_CTL    7'h03
`define SBRB_ADDR_BUS_ONE     7'h04
`define SBRB_ADDR_BUS_TWO     7'h05
`define SBRB_ADDR_WAKE_ONE    7'h06
`define SBRB_ADDR_WAKE_TWO    7'h07
`define SBRB_ADDR_WAKE_PULL   7'h08
`define SBRB_ADDR_WAKE_FILT   7'h09
`define SBRB_ADDR_TMR_ONE     7'h0C
`define SBRB_ADDR_TMR_TWO     7'h0D
`define SBRB_ADDR_SW_SHDN     7'h10
`define SBRB_ADDR_HS_ONE      7'h14
`define SBRB_CTRL_LAST        7'h1E

// Status ranges: clearable bank, live bank, identifier.
`define SBRB_STAT_FIRST       7'h40
`define SBRB_STAT_LAST        7'h7E
`define SBRB_STAT_CLR_BASE    4'h8
`define SBRB_STAT_LIVE_BASE   4'hE
`define SBRB_ADDR_FAM_PROD    7'h7E

// Frame layout and length.
`define SBRB_FRAME_BITS       5'h10
`define SBRB_ADDR_BITS        5'h07
`define SBRB_BIT_ACT          7

// Fields inside control registers.
`define SBRB_MODE_HI          7
`define SBRB_MODE_LO          5
`define SBRB_SECOND_REGULATOR_OUTPUT_HI          4
`define SBRB_SECOND_REGULATOR_OUTPUT_LO          3
`define SBRB_CAN_HI           1
`define SBRB_CAN_LO           0
`define SBRB_HS_FIELD_W       4

// Transceiver field codes.
`define SBRB_CAN_OFF          2'h0
`define SBRB_CAN_WAKE         2'h1

// Operating mode codes.
`define SBRB_MODE_NORMAL      3'h0
`define SBRB_MODE_SLEEP       3'h1
`define SBRB_MODE_STOP        3'h2
`define SBRB_MODE_RESTART     3'h3

// Reset values.
`define SBRB_CTRL_RST         8'h00
`define SBRB_STAT_RST         8'h00

`endif

// *** hdl/sbrb_sync.v ***
/*
 * Two-stage synchroniser for a group of asynchronous level inputs.
 * Assumes each input is stable for several sys_clk periods.
 */
`timescale 1ns/10ps

module sbrb_sync #(
   parameter WIDTH = 3
) (
   // Clock
   sys_clk,
   // Asynchronous levels in, synchronised levels out
   async_in,
   sync_out
);
   input  wire             sys_clk;
   input  wire [WIDTH-1:0] async_in;
   output wire [WIDTH-1:0] sync_out;

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
         always @(posedge sys_clk) begin
            meta_q[gi] <= async_in[gi];
            sync_q[gi] <= meta_q[gi];
         end
      end
   endgenerate

   assign sync_out = sync_q;

endmodule // sbrb_sync

// *** bench/sbrb_bank_assertions.sv ***
/* Concurrent checks on the mode, switch and fail outputs of the bank.
   Sees only the bank's ports; bound to the bank at the foot of the file. */
`timescale 1ns/10ps
`include "sbrb_map.vh"
module sbrb_bank_assertions #(
   parameter N_HS   = 2,
   parameter N_STAT = 8,
   parameter N_LIVE = 7
) (
   // Clock and reset
   input wire            sys_clk,
   input wire            srst,
   // Serial select and data output enable
   input wire            spi_cs_n,
   input wire            spi_sdo_oe,
   // Mode and diagnosis
   input wire [2:0]      mode_now,
   input wire [N_HS-1:0] hs_fail,
   input wire            fail_trigger,
   input wire            fail_out,
   // Control registers
   input wire [7:0]      mode_select_control,
   input wire [7:0]      hardware_control,
   input wire [7:0]      bus_control_one,
   input wire [7:0]      high_side_control_one
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////
   property p_mode_field;
      mode_now != $past(mode_now) |=>
         mode_select_control[7:5] == $past(mode_now);
   endproperty
   a_mode_field: assert property (p_mode_field)
      else $error("mode field misses the entered mode");
   property p_stop_bus;
      mode_now != $past(mode_now) && mode_now == `SBRB_MODE_STOP |=>
         $stable(bus_control_one[1:0]);
   endproperty
   a_stop_bus: assert property (p_stop_bus)
      else $error("transceiver bits altered on entering stop");
   property p_sleep_bus;
      mode_now != $past(mode_now) && mode_now == `SBRB_MODE_SLEEP &&
         bus_control_one[1] |=> bus_control_one[1:0] == `SBRB_CAN_WAKE;
   endproperty
   a_sleep_bus: assert property (p_sleep_bus)
      else $error("transceiver bits not rewritten on entering sleep");
   property p_restart_clr;
      mode_now != $past(mode_now) && mode_now == `SBRB_MODE_RESTART |=>
         high_side_control_one == 8'h00 && hardware_control[4:3] == 2'h0;
   endproperty
   a_restart_clr: assert property (p_restart_clr)
      else $error("switch or regulator config kept in restart");
   property p_hs_fail_lo;
      hs_fail[0] |=> high_side_control_one[3:0] == 4'h0;
   endproperty
   a_hs_fail_lo: assert property (p_hs_fail_lo)
      else $error("failed switch zero left on");
   property p_hs_fail_hi;
      hs_fail[N_HS-1] [*2] |-> high_side_control_one[7:4] == 4'h0;
   endproperty
   a_hs_fail_hi: assert property (p_hs_fail_hi)
      else $error("failed switch one left on");
   // A low-power entry must never drop the fail output once it is set.
   property p_fail_keep;
      fail_out |=> fail_out;
   endproperty
   a_fail_keep: assert property (p_fail_keep)
      else $error("fail output released");
   property p_fail_set;
      fail_trigger |=> fail_out [*3];
   endproperty
   a_fail_set: assert property (p_fail_set)
      else $error("fail output not raised by trigger");
   // Outside normal mode switch bits may only fall, never rise.
   property p_hs_normal;
      mode_now != `SBRB_MODE_NORMAL && $past(mode_now) != `SBRB_MODE_NORMAL
         |-> (high_side_control_one & ~$past(high_side_control_one)) == 8'h00;
   endproperty
   a_hs_normal: assert property (p_hs_normal)
      else $error("switch config accepted outside normal mode");
   property p_second_regulator_output_normal;
      $past(mode_now) != `SBRB_MODE_NORMAL |->
         (hardware_control[4:3] & ~$past(hardware_control[4:3])) == 2'h0;
   endproperty
   a_second_regulator_output_normal: assert property (p_second_regulator_output_normal)
      else $error("regulator config accepted outside normal mode");
   // Two synchroniser stages plus the output flop after select falls.
   property p_oe_follow;
      $fell(spi_cs_n) |-> ##3 spi_sdo_oe;
   endproperty
   a_oe_follow: assert property (p_oe_follow)
      else $error("data output not enabled in a frame");
endmodule // sbrb_bank_assertions

bind sbrb_bank sbrb_bank_assertions #(.N_HS(N_HS), .N_STAT(N_STAT),
   .N_LIVE(N_LIVE)) u_sbrb_bank_assertions (.sys_clk(sys_clk),
   .srst(srst), .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe),
   .mode_now(mode_now), .hs_fail(hs_fail),
   .fail_trigger(fail_trigger), .fail_out(fail_out),
   .mode_select_control(mode_select_control),
   .hardware_control(hardware_control), .bus_control_one(bus_control_one),
   .high_side_control_one(high_side_control_one));

// *** bench/sbrb_spi_master.sv ***
/* Serial master model standing in for the microcontroller.
   Assumes the bank samples at SCLK rise and shifts SDO at SCLK fall. */
`timescale 1ns/10ps
module sbrb_spi_master (
   // Clock
   input  wire  sys_clk,
   // Serial pins
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic spi_sdi,
   input  wire  spi_sdo
);
   // Six cycles a half period keeps SCLK well under sys_clk/8.
   localparam int HALF = 6;
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_sdi  = 1'b0;
   end
   // A count other than 16 makes a frame the bank must discard.
   task automatic xfer(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge sys_clk) spi_cs_n <= 1'b0;
      repeat (HALF) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         spi_sdi <= tx[i];
         repeat (HALF) @(posedge sys_clk);
         rx[i] = spi_sdo;
         spi_sclk <= 1'b1;
         repeat (HALF) @(posedge sys_clk);
         spi_sclk <= 1'b0;
      end
      repeat (HALF) @(posedge sys_clk);
      spi_cs_n <= 1'b1;
      // Idle data is inverted so a stale bit is never mistaken for data.
      spi_sdi  <= ~spi_sdi;
      repeat (2 * HALF) @(posedge sys_clk);
   endtask
endmodule // sbrb_spi_master

// *** bench/sbrb_bank_test.sv ***
/* Self-checking bench for the serial register bank.
   Assumes sbrb_map.vh on the include path and the serial master model. */
`timescale 1ns/10ps
`include "sbrb_map.vh"
module sbrb_bank_test;
   localparam logic [7:0]  ID = 8'hC3;  // Arbitrary identifier value.
   localparam logic [63:0] SP = 64'hF0E1D2C3B4A59687;
   localparam logic [6:0]  CA [13] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
      7'h06, 7'h07, 7'h08, 7'h09, 7'h0C, 7'h0D, 7'h10, 7'h14};
   logic        sys_clk, srst, spi_cs_n, spi_sclk, spi_sdi, spi_sdo;
   logic        spi_sdo_oe, fail_trigger, fail_out;
   logic [2:0]  mode_now;
   logic [1:0]  hs_fail;
   logic [63:0] stat_set;
   logic [55:0] stat_live;
   logic [15:0] rx;
   logic [7:0]  ctl [13];
   int          bad_count, compares;
   ////////////////////////////////////////////////////////////////////////
   sbrb_bank #(.FAM_PROD_ID(ID)) u_sbrb_bank (.sys_clk(sys_clk),
      .srst(srst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
      .mode_now(mode_now), .hs_fail(hs_fail), .fail_trigger(fail_trigger),
      .stat_set(stat_set), .stat_live(stat_live), .fail_out(fail_out),
      .mode_select_control(ctl[0]), .hardware_control(ctl[1]),
      .watchdog_control(ctl[2]), .bus_control_one(ctl[3]),
      .bus_control_two(ctl[4]), .wake_control_one(ctl[5]),
      .wake_control_two(ctl[6]), .wake_pull_control(ctl[7]),
      .wake_filter_control(ctl[8]), .timer_one_control(ctl[9]),
      .timer_two_control(ctl[10]), .switch_shutdown_control(ctl[11]),
      .high_side_control_one(ctl[12]));
   sbrb_spi_master u_sbrb_spi_master (.sys_clk(sys_clk),
      .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] cv(input logic [6:0] a);
      return {a[3:0], ~a[3:0]};
   endfunction
   task automatic check(input string what, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic ex(input logic [6:0] a, input logic w,
                     input logic [7:0] d, e);
      u_sbrb_spi_master.xfer({d, w, a}, 16, rx);
      check($sformatf("register %h", a), e, rx[15:8]);
      check("response low byte", 8'h00, rx[7:0]);
   endtask
   task automatic setm(input logic [2:0] m);
      @(posedge sys_clk) mode_now <= m;
      repeat (4) @(posedge sys_clk);
      check("mode field", {5'h0, m}, {5'h0, ctl[0][7:5]});
   endtask
   task automatic complete_run;
      if (bad_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      complete_run;
   end
   initial begin
      srst = 1'b1;
      mode_now = `SBRB_MODE_NORMAL;
      hs_fail = 2'h0;
      fail_trigger = 1'b0;
      stat_set = 64'h0;
      stat_live = 56'h96959493929190;
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      foreach (CA[i]) ex(CA[i], 1'b0, 8'hFF, 8'h00);
      foreach (CA[i]) ex(CA[i], 1'b1, cv(CA[i]), 8'h00);
      foreach (CA[i]) ex(CA[i], 1'b0, 8'h00, cv(CA[i]));
      foreach (CA[i]) check("control port", cv(CA[i]), ctl[i]);
      ex(7'h0A, 1'b1, 8'h77, 8'h00);
      ex(7'h0A, 1'b0, 8'h00, 8'h00);
      u_sbrb_spi_master.xfer({8'h00, 1'b1, 7'h05}, 15, rx);
      ex(7'h05, 1'b0, 8'h00, cv(7'h05));
      @(posedge sys_clk) stat_set <= SP;
      @(posedge sys_clk) stat_set <= 64'h0;
      for (int i = 0; i < 8; i++) begin
         ex({4'h8, i[2:0]}, 1'b0, 8'h00, SP[8*i+:8]);
         ex({4'h8, i[2:0]}, 1'b1, 8'h00, SP[8*i+:8]);
         ex({4'h8, i[2:0]}, 1'b0, 8'h00, 8'h00);
      end
      for (int i = 0; i < 7; i++) begin
         ex({4'hE, i[2:0]}, 1'b1, 8'h00, {5'h12, i[2:0]});
         ex({4'hE, i[2:0]}, 1'b0, 8'h00, {5'h12, i[2:0]});
      end
      ex(7'h7E, 1'b1, 8'h00, ID);
      ex(7'h7E, 1'b0, 8'h00, ID);
      @(posedge sys_clk) hs_fail <= 2'h3;
      fail_trigger <= 1'b1;
      repeat (2) @(posedge sys_clk);
      hs_fail <= 2'h0;
      fail_trigger <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("switch control", 8'h00, ctl[12]);
      check("fail output", 8'h01, {7'h0, fail_out});
      @(posedge sys_clk) stat_set <= SP;
      @(posedge sys_clk) stat_set <= 64'h0;
      ex(7'h14, 1'b1, 8'h4B, 8'h00);
      check("switch control", 8'h4B, ctl[12]);
      setm(`SBRB_MODE_STOP);
      check("transceiver", cv(7'h04), ctl[3]);
      ex(7'h14, 1'b1, 8'hFF, 8'h4B);
      check("switch control", 8'h4B, ctl[12]);
      ex(7'h02, 1'b1, 8'hFF, 8'h2D);
      setm(`SBRB_MODE_SLEEP);
      check("transceiver", 8'h49, ctl[3]);
      check("hardware control", 8'hEF, ctl[1]);
      ex(7'h40, 1'b0, 8'h00, SP[7:0]);
      setm(`SBRB_MODE_RESTART);
      check("switch control", 8'h00, ctl[12]);
      check("hardware control", 8'hE7, ctl[1]);
      ex(7'h03, 1'b1, 8'hEE, cv(7'h03));
      setm(`SBRB_MODE_NORMAL);
      ex(7'h03, 1'b0, 8'h00, cv(7'h03));
      check("fail output", 8'h01, {7'h0, fail_out});
      complete_run;
   end
endmodule // sbrb_bank_test
